// File: design/swc_top.sv
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module swc_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        sleep_op,
    input  wire logic        watchdog_clear_op,
    input  wire logic        tmr0_flag_set,
    input  wire logic        ext_int_flag_set,
    input  wire logic [7:0]  portb_change,
    input  wire logic [7:0]  per_flag_set_one,
    input  wire logic [7:0]  per_flag_set_two,
    output logic             osc_run,
    output logic             core_stall,
    output logic             exec_next,
    output logic             vector_jump,
    output logic      [12:0] vector_addr,
    output logic             irq
);
    // ***********************************************
    // Declarations
    // ***********************************************
    swc_ost_if ost_if ();
    swc_pkg::swc_state_e        state_ff, nxt_state;
    logic [7:0] int_ctrl_ff, peripheral_irq_enable_one_ff, peripheral_irq_enable_two_ff, peripheral_irq_flags_one_ff, peripheral_irq_flags_two_ff, portb_change_irq_enable_ff;
    logic [7:0] nxt_int_ctrl, nxt_peripheral_irq_enable_one, nxt_peripheral_irq_enable_two, nxt_peripheral_irq_flags_one, nxt_peripheral_irq_flags_two, nxt_portb_change_irq_enable;
    logic [2:0]                 osc_mode_ff, nxt_osc_mode;
    logic [swc_pkg::EV_W-1:0]   ev_st_ff, ev_en_ff, nxt_ev_st, nxt_ev_en, ev_set;
    logic [7:0]                 rdata_ff, nxt_rdata;
    logic [swc_pkg::WD_PRE_W-1:0] wd_pre_ff, nxt_wd_pre;
    logic [swc_pkg::WD_CNT_W-1:0] watchdog_counter_ff, nxt_watchdog_counter;
    logic                       timeout_status_n_ff, nxt_timeout_status_n;
    logic                       powerdown_status_n_ff, nxt_powerdown_status_n;
    logic [1:0]                 dummy_ff, nxt_dummy;
    logic                       vec_sel_ff, nxt_vec_sel;
    logic                       exec_ff, nxt_exec, vec_ff, nxt_vec;
    logic [12:0]                vaddr_ff, nxt_vaddr;
    logic                       osc_ff, nxt_osc;
    logic                       wake_cond, crystal, sleep_take, sleep_nop, wd_wrap;
    logic [7:0]                 int_flag_set;

    // Sticky flag update; hardware set wins over a software write
    function automatic logic [7:0] set_win(input logic [7:0] cur, input logic [7:0] set,
                                           input logic we, input logic [7:0] wd);
        set_win = (we ? wd : cur) | set;
    endfunction

    function automatic logic wr_hit(input logic [3:0] a);
        wr_hit = reg_wr && (reg_addr == a);
    endfunction

    // ***********************************************
    // Wake decode
    // ***********************************************
    // enable and flag pairs
    assign wake_cond =
        (int_ctrl_ff[swc_pkg::TMR0_IEN_BIT] && int_ctrl_ff[swc_pkg::TMR0_FLG_BIT]) ||
        (int_ctrl_ff[swc_pkg::EXT_IEN_BIT]  && int_ctrl_ff[swc_pkg::EXT_FLG_BIT])  ||
        (int_ctrl_ff[swc_pkg::PCHG_IEN_BIT] && int_ctrl_ff[swc_pkg::PCHG_FLG_BIT]) ||
        (|(peripheral_irq_enable_one_ff & peripheral_irq_flags_one_ff)) || (|(peripheral_irq_enable_two_ff & peripheral_irq_flags_two_ff));

    // only crystal modes need start-up delay
    assign crystal = (osc_mode_ff == swc_pkg::CRYSTAL_MODE_LOW_POWER) ||
                     (osc_mode_ff == swc_pkg::CRYSTAL_MODE_STANDARD)  ||
                     (osc_mode_ff == swc_pkg::CRYSTAL_MODE_HIGH_SPEED);

    // pending wake turns sleep into no-operation
    assign sleep_nop  = sleep_op && (state_ff == swc_pkg::ST_RUN) && wake_cond;
    assign sleep_take = sleep_op && (state_ff == swc_pkg::ST_RUN) && !wake_cond;

    // Port change flag is gated per pin by its enable
    assign int_flag_set = {5'h00, tmr0_flag_set, ext_int_flag_set, |(portb_change & portb_change_irq_enable_ff)};

    // ***********************************************
    // Register file
    // ***********************************************
    always_comb begin
        nxt_int_ctrl = set_win(int_ctrl_ff, int_flag_set, wr_hit(swc_pkg::A_INT_CTRL),
                               reg_wdata);
        nxt_peripheral_irq_enable_one     = wr_hit(swc_pkg::A_PER_IEN1)  ? reg_wdata : peripheral_irq_enable_one_ff;
        nxt_peripheral_irq_enable_two     = wr_hit(swc_pkg::A_PER_IEN2)  ? reg_wdata : peripheral_irq_enable_two_ff;
        nxt_portb_change_irq_enable     = wr_hit(swc_pkg::A_PORTB_CHG) ? reg_wdata : portb_change_irq_enable_ff;
        nxt_peripheral_irq_flags_one     = set_win(peripheral_irq_flags_one_ff, per_flag_set_one, wr_hit(swc_pkg::A_PER_FLAG1),
                               reg_wdata);
        nxt_peripheral_irq_flags_two     = set_win(peripheral_irq_flags_two_ff, per_flag_set_two, wr_hit(swc_pkg::A_PER_FLAG2),
                               reg_wdata);
        nxt_osc_mode = wr_hit(swc_pkg::A_OSC_MODE) ? reg_wdata[2:0] : osc_mode_ff;
        nxt_ev_en    = wr_hit(swc_pkg::A_EVT_ENABLE) ? reg_wdata[swc_pkg::EV_W-1:0] : ev_en_ff;
        // Clear by writing ones; a same-cycle event keeps its bit
        nxt_ev_st    = (ev_st_ff & ~(wr_hit(swc_pkg::A_EVT_CLEAR) ?
                        reg_wdata[swc_pkg::EV_W-1:0] : 4'h0)) | ev_set;
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                swc_pkg::A_INT_CTRL:   nxt_rdata = int_ctrl_ff;
                swc_pkg::A_PER_IEN1:   nxt_rdata = peripheral_irq_enable_one_ff;
                swc_pkg::A_PER_IEN2:   nxt_rdata = peripheral_irq_enable_two_ff;
                swc_pkg::A_PER_FLAG1:  nxt_rdata = peripheral_irq_flags_one_ff;
                swc_pkg::A_PER_FLAG2:  nxt_rdata = peripheral_irq_flags_two_ff;
                swc_pkg::A_PORTB_CHG:  nxt_rdata = portb_change_irq_enable_ff;
                swc_pkg::A_PWR_STATUS: nxt_rdata = {3'h0, state_ff, timeout_status_n_ff,
                                                    powerdown_status_n_ff};
                swc_pkg::A_OSC_MODE:   nxt_rdata = {5'h00, osc_mode_ff};
                swc_pkg::A_WATCHDOG:   nxt_rdata = watchdog_counter_ff;
                swc_pkg::A_EVT_STATUS: nxt_rdata = {4'h0, ev_st_ff};
                swc_pkg::A_EVT_ENABLE: nxt_rdata = {4'h0, ev_en_ff};
                default:               nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            int_ctrl_ff <= swc_pkg::RST_REG8;
            peripheral_irq_enable_one_ff     <= swc_pkg::RST_REG8;
            peripheral_irq_enable_two_ff     <= swc_pkg::RST_REG8;
            peripheral_irq_flags_one_ff     <= swc_pkg::RST_REG8;
            peripheral_irq_flags_two_ff     <= swc_pkg::RST_REG8;
            portb_change_irq_enable_ff     <= swc_pkg::RST_REG8;
            osc_mode_ff <= swc_pkg::RST_OSC;
            ev_en_ff    <= '0;
            ev_st_ff    <= '0;
            rdata_ff    <= 8'h00;
        end else begin
            int_ctrl_ff <= nxt_int_ctrl;
            peripheral_irq_enable_one_ff     <= nxt_peripheral_irq_enable_one;
            peripheral_irq_enable_two_ff     <= nxt_peripheral_irq_enable_two;
            peripheral_irq_flags_one_ff     <= nxt_peripheral_irq_flags_one;
            peripheral_irq_flags_two_ff     <= nxt_peripheral_irq_flags_two;
            portb_change_irq_enable_ff     <= nxt_portb_change_irq_enable;
            osc_mode_ff <= nxt_osc_mode;
            ev_en_ff    <= nxt_ev_en;
            ev_st_ff    <= nxt_ev_st;
            rdata_ff    <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq       = |(ev_st_ff & ev_en_ff);

    // ***********************************************
    // Watchdog and status bits
    // ***********************************************
    assign wd_wrap = (&wd_pre_ff) && (&watchdog_counter_ff);

    always_comb begin
        nxt_wd_pre             = wd_pre_ff + 7'h01;
        nxt_watchdog_counter   = (&wd_pre_ff) ? watchdog_counter_ff + 8'h01
                                              : watchdog_counter_ff;
        nxt_timeout_status_n   = wd_wrap ? 1'b0 : timeout_status_n_ff;
        nxt_powerdown_status_n = powerdown_status_n_ff;
        if (watchdog_clear_op) begin
            nxt_wd_pre             = '0;
            nxt_watchdog_counter   = '0;
            nxt_timeout_status_n   = 1'b1;
            nxt_powerdown_status_n = 1'b1;
        end else if (sleep_take) begin
            nxt_wd_pre             = '0;
            nxt_watchdog_counter   = '0;
            nxt_timeout_status_n   = 1'b1;
            nxt_powerdown_status_n = 1'b0;
        end
        // no-operation sleep falls through, bits untouched
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wd_pre_ff             <= '0;
            watchdog_counter_ff   <= '0;
            timeout_status_n_ff   <= 1'b1;
            powerdown_status_n_ff <= 1'b1;
        end else begin
            wd_pre_ff             <= nxt_wd_pre;
            watchdog_counter_ff   <= nxt_watchdog_counter;
            timeout_status_n_ff   <= nxt_timeout_status_n;
            powerdown_status_n_ff <= nxt_powerdown_status_n;
        end
    end

    // ***********************************************
    // Sleep and wake sequencer
    // ***********************************************
    assign ev_set = {wd_wrap, (state_ff == swc_pkg::ST_SLEEP) && wake_cond, sleep_nop,
                     sleep_take};

    always_comb begin
        nxt_state    = state_ff;
        nxt_dummy    = dummy_ff;
        nxt_vec_sel  = vec_sel_ff;
        nxt_exec     = 1'b0;
        nxt_vec      = 1'b0;
        nxt_vaddr    = vaddr_ff;
        ost_if.start = 1'b0;
        unique case (state_ff)
            swc_pkg::ST_RUN: begin
                if (sleep_take) begin
                    nxt_state = swc_pkg::ST_SLEEP;
                end
            end
            // sleep already completed, wake at once
            swc_pkg::ST_SLEEP: begin
                if (wake_cond) begin
                    if (crystal) begin
                        nxt_state    = swc_pkg::ST_OST;
                        ost_if.start = 1'b1;
                    end else begin
                        nxt_state = swc_pkg::ST_RESUME;
                    end
                end
            end
            swc_pkg::ST_OST: begin
                if (ost_if.done) begin
                    nxt_state = swc_pkg::ST_RESUME;
                end
            end
            // global enable picks vector or in-line
            swc_pkg::ST_RESUME: begin
                nxt_exec    = 1'b1;
                nxt_vec_sel = int_ctrl_ff[swc_pkg::GLB_IEN_BIT];
                nxt_dummy   = 2'h0;
                nxt_state   = int_ctrl_ff[swc_pkg::GLB_IEN_BIT] ? swc_pkg::ST_DUMMY
                                                               : swc_pkg::ST_RUN;
            end
            swc_pkg::ST_DUMMY: begin
                nxt_dummy = dummy_ff + 2'h1;
                if (dummy_ff == swc_pkg::DUMMY_LAST) begin
                    nxt_vec   = 1'b1;
                    nxt_vaddr = swc_pkg::VECTOR_ADDR;
                    nxt_state = swc_pkg::ST_RUN;
                end
            end
            default: nxt_state = swc_pkg::ST_RUN;
        endcase
        nxt_osc = (nxt_state != swc_pkg::ST_SLEEP);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff   <= swc_pkg::ST_RUN;
            dummy_ff   <= 2'h0;
            vec_sel_ff <= 1'b0;
            exec_ff    <= 1'b0;
            vec_ff     <= 1'b0;
            vaddr_ff   <= 13'h0000;
            osc_ff     <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            dummy_ff   <= nxt_dummy;
            vec_sel_ff <= nxt_vec_sel;
            exec_ff    <= nxt_exec;
            vec_ff     <= nxt_vec;
            vaddr_ff   <= nxt_vaddr;
            osc_ff     <= nxt_osc;
        end
    end

    swc_ost_timer u_ost (
        .clk   (clk),
        .rst_n (rst_n),
        .ost   (ost_if.tmr)
    );

    assign osc_run     = osc_ff;
    assign core_stall  = (state_ff == swc_pkg::ST_SLEEP) || (state_ff == swc_pkg::ST_OST);
    assign exec_next   = exec_ff;
    assign vector_jump = vec_ff;
    assign vector_addr = vaddr_ff;

    // ***********************************************
    // Assertions
    // ***********************************************
    logic [10:0] ost_len_ff;
    always_ff @(posedge clk) begin
        if (!rst_n || state_ff != swc_pkg::ST_OST) begin
            ost_len_ff <= 11'h000;
        end else begin
            ost_len_ff <= ost_len_ff + 11'h001;
        end
    end
    localparam logic [10:0] OST_LAST = 11'(swc_pkg::OST_CYCLES - 1);

    property p_wake_any;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == swc_pkg::ST_SLEEP) && wake_cond && !int_ctrl_ff[swc_pkg::GLB_IEN_BIT]
        |=> state_ff != swc_pkg::ST_SLEEP;
    endproperty
    a_wake_any: assert property (p_wake_any) else $error("no wake with global off");

    property p_nop_sleep;
        @(posedge clk) disable iff (!rst_n)
        sleep_op && (state_ff == swc_pkg::ST_RUN) && wake_cond
        |=> (state_ff == swc_pkg::ST_RUN) && osc_run;
    endproperty
    a_nop_sleep: assert property (p_nop_sleep) else $error("pending wake still slept");

    property p_nop_keep;
        @(posedge clk) disable iff (!rst_n)
        sleep_nop && !watchdog_clear_op && !wd_wrap
        |=> $stable(timeout_status_n_ff) && $stable(powerdown_status_n_ff)
            && watchdog_counter_ff >= $past(watchdog_counter_ff);
    endproperty
    a_nop_keep: assert property (p_nop_keep) else $error("nop sleep touched state");

    property p_sleep_done;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == swc_pkg::ST_SLEEP) && wake_cond
        |=> state_ff inside {swc_pkg::ST_OST, swc_pkg::ST_RESUME} && !powerdown_status_n_ff;
    endproperty
    a_sleep_done: assert property (p_sleep_done) else $error("late wake mishandled");

    property p_sleep_in;
        @(posedge clk) disable iff (!rst_n)
        sleep_take |=> (watchdog_counter_ff == 8'h00) && (wd_pre_ff == 7'h00)
                        && timeout_status_n_ff && !powerdown_status_n_ff;
    endproperty
    a_sleep_in: assert property (p_sleep_in) else $error("sleep entry state wrong");

    property p_nop_pd;
        @(posedge clk) disable iff (!rst_n)
        sleep_nop && powerdown_status_n_ff |=> powerdown_status_n_ff;
    endproperty
    a_nop_pd: assert property (p_nop_pd) else $error("powerdown bit cleared on nop");

    property p_wd_clear;
        @(posedge clk) disable iff (!rst_n)
        watchdog_clear_op |=> (watchdog_counter_ff == 8'h00) && (wd_pre_ff == 7'h00)
                              && timeout_status_n_ff && powerdown_status_n_ff;
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("watchdog clear incomplete");

    property p_ost_len;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == swc_pkg::ST_OST) && ost_if.done |-> ost_len_ff == OST_LAST;
    endproperty
    a_ost_len: assert property (p_ost_len) else $error("start-up delay length wrong");

    property p_no_ost;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == swc_pkg::ST_SLEEP) && wake_cond && !crystal
        |=> state_ff == swc_pkg::ST_RESUME;
    endproperty
    a_no_ost: assert property (p_no_ost) else $error("delay applied in non-crystal mode");

    property p_inline;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == swc_pkg::ST_RESUME) && !int_ctrl_ff[swc_pkg::GLB_IEN_BIT]
        |=> exec_next && !vector_jump ##1 !vector_jump [*4];
    endproperty
    a_inline: assert property (p_inline) else $error("in-line wake vectored");

    property p_vector;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == swc_pkg::ST_RESUME) && int_ctrl_ff[swc_pkg::GLB_IEN_BIT]
        |=> exec_next ##1 !vector_jump [*2] ##1 vector_jump && (vector_addr == 13'h0004);
    endproperty
    a_vector: assert property (p_vector) else $error("vector sequence wrong");

    property p_osc_off;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == swc_pkg::ST_SLEEP) |-> !osc_run && core_stall;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator ran in sleep");

    c_nop: cover property (@(posedge clk) disable iff (!rst_n) sleep_nop);
    c_vec: cover property (@(posedge clk) disable iff (!rst_n) vector_jump);
    c_ost: cover property (@(posedge clk) disable iff (!rst_n)
                           (state_ff == swc_pkg::ST_OST) && ost_if.done);
    c_inl: cover property (@(posedge clk) disable iff (!rst_n) exec_next && !vec_sel_ff);
endmodule // swc_top
`default_nettype wire

// File: design/swc_pkg.sv
// Function
// - Any source with both enable and flag set is a wake condition, ignoring global enable.
// - A sleep request with a wake condition already pending acts as a no-operation.
// - A no-operation sleep does not clear watchdog or prescaler and leaves both status bits unchanged.
// - A wake arising during or after sleep completes the sleep, then wakes at once.
// - Entering sleep clears watchdog and prescaler, sets timeout, clears powerdown bit.
// - Powerdown bit stays set after a no-operation sleep so software can tell.
// - Watchdog clear zeroes counter and prescaler and sets both status bits.
// - Crystal modes wait 1024 oscillator periods on wake; external and RC skip it.
// - After wake, global enable set jumps to vector 0004h, else continues in line.
// - The system oscillator is held stopped while asleep until a wake event.
package swc_pkg;
    // ***********************************************
    // Register map
    // ***********************************************
    localparam logic [3:0] A_INT_CTRL     = 4'h0;
    localparam logic [3:0] A_PER_IEN1     = 4'h1;
    localparam logic [3:0] A_PER_IEN2     = 4'h2;
    localparam logic [3:0] A_PER_FLAG1    = 4'h3;
    localparam logic [3:0] A_PER_FLAG2    = 4'h4;
    localparam logic [3:0] A_PORTB_CHG    = 4'h5;
    localparam logic [3:0] A_PWR_STATUS   = 4'h6;
    localparam logic [3:0] A_OSC_MODE     = 4'h7;
    localparam logic [3:0] A_WATCHDOG     = 4'h8;
    localparam logic [3:0] A_EVT_STATUS   = 4'h9;
    localparam logic [3:0] A_EVT_CLEAR    = 4'ha;
    localparam logic [3:0] A_EVT_ENABLE   = 4'hb;

    // ***********************************************
    // Field positions and reset values
    // ***********************************************
    localparam int GLB_IEN_BIT  = 7;
    localparam int TMR0_IEN_BIT = 5;
    localparam int EXT_IEN_BIT  = 4;
    localparam int PCHG_IEN_BIT = 3;
    localparam int TMR0_FLG_BIT = 2;
    localparam int EXT_FLG_BIT  = 1;
    localparam int PCHG_FLG_BIT = 0;
    localparam int PWR_PD_BIT   = 0;
    localparam int PWR_TO_BIT   = 1;
    localparam int PWR_ST_LSB   = 2;
    localparam int EV_SLEEP     = 0;
    localparam int EV_NOP       = 1;
    localparam int EV_WAKE      = 2;
    localparam int EV_WDOG      = 3;
    localparam int EV_W         = 4;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;

    // ***********************************************
    // Watchdog and timing
    // ***********************************************
    localparam int WD_PRE_W = 7;
    localparam int WD_CNT_W = 8;
    localparam int OST_PERIODS   = 1024;
    localparam int OSC_PERIOD_NS = 50;
    localparam int CLK_PERIOD_NS = 50;
    localparam int OST_CYCLES =
        (OST_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OST_W = 11;
    localparam logic [1:0] DUMMY_LAST = 2'h2;

    typedef enum logic [2:0] {
        CRYSTAL_MODE_LOW_POWER = 3'b000,
        CRYSTAL_MODE_STANDARD  = 3'b001,
        CRYSTAL_MODE_HIGH_SPEED = 3'b010,
        EXTERNAL_CLOCK_MODE    = 3'b011,
        RESISTOR_CAP_OSC_MODE  = 3'b100
    } swc_osc_e;
    localparam logic [2:0] RST_OSC = 3'b001;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_SLEEP  = 3'b001,
        ST_OST    = 3'b010,
        ST_RESUME = 3'b011,
        ST_DUMMY  = 3'b100
    } swc_state_e;
endpackage

// File: design/swc_ost_if.sv
`timescale 1ns/1ps
`default_nettype none
// Start-up delay handshake between sequencer and timer
interface swc_ost_if;
    logic start;
    logic done;
    modport ctl (output start, input done);
    modport tmr (input start, output done);
endinterface
`default_nettype wire

// File: design/swc_ost_timer.sv
`timescale 1ns/1ps
`default_nettype none
module swc_ost_timer (
    input  wire logic clk,
    input  wire logic rst_n,
    swc_ost_if.tmr    ost
);
    localparam logic [10:0] LAST = 11'(swc_pkg::OST_CYCLES - 1);
    logic                       busy_ff;
    logic                       nxt_busy;
    logic [swc_pkg::OST_W-1:0]  cnt_ff;
    logic [swc_pkg::OST_W-1:0]  nxt_cnt;

    // Done is combinational so the sequencer leaves on the last cycle
    assign ost.done = busy_ff && (cnt_ff == LAST);

    // Count oscillator periods while busy
    always_comb begin
        nxt_busy = busy_ff;
        nxt_cnt  = cnt_ff;
        if (ost.start) begin
            nxt_busy = 1'b1;
            nxt_cnt  = '0;
        end else if (busy_ff) begin
            nxt_cnt = cnt_ff + 11'h001;
            if (ost.done) begin
                nxt_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
            cnt_ff  <= '0;
        end else begin
            busy_ff <= nxt_busy;
            cnt_ff  <= nxt_cnt;
        end
    end

    property p_ost_len;
        @(posedge clk) disable iff (!rst_n)
        busy_ff && !ost.done && !ost.start
        |=> busy_ff && (cnt_ff == $past(cnt_ff) + 11'h001);
    endproperty
    a_ost_len: assert property (p_ost_len) else $error("start-up delay end miscounted");
endmodule // swc_ost_timer
`default_nettype wire

// File: verification/swc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Core side interrupt sources
// ****
module swc_core_model (
    input  wire logic       clk,
    input  wire logic       kick_ext,
    input  wire logic [7:0] kick_per,
    output logic            ext_set,
    output logic      [7:0] per_set
);
    // Flag set pulses trail the request by one cycle, like real hardware
    always_ff @(posedge clk) begin
        ext_set <= kick_ext;
        per_set <= kick_per;
    end
endmodule // swc_core_model
`default_nettype wire

// File: verification/sleep_wake_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_controller_tb;
    logic        clk, rst_n, reg_wr, reg_rd, sleep_op, wdc, kick_ext, ext_set;
    logic        osc_run, core_stall, exec_next, vector_jump, irq;
    logic [3:0]  addr;
    logic [7:0]  wd, rdata, d, r, kick_per, per_set;
    logic [12:0] vaddr;
    int          err_count, cmp_count, c, b;

    swc_top u_swc_top (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .sleep_op(sleep_op),
        .watchdog_clear_op(wdc), .tmr0_flag_set(1'b0), .ext_int_flag_set(ext_set),
        .portb_change(8'h00), .per_flag_set_one(per_set), .per_flag_set_two(8'h00),
        .osc_run(osc_run), .core_stall(core_stall), .exec_next(exec_next),
        .vector_jump(vector_jump), .vector_addr(vaddr), .irq(irq));
    swc_core_model u_swc_core_model (.clk(clk), .kick_ext(kick_ext), .kick_per(kick_per),
        .ext_set(ext_set), .per_set(per_set));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wd <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data is taken in the single cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic pulse(input logic s, input logic w, input logic e, input logic [7:0] p);
        @(posedge clk);
        {sleep_op, wdc, kick_ext, kick_per} <= {s, w, e, p};
        @(posedge clk);
        {sleep_op, wdc, kick_ext, kick_per} <= 11'h000;
        // Let the edge settle so callers see registered state
        #1;
    endtask
    // Bounded wait for the resume pulse, cycles counted in c
    task automatic wait_exec;
        c = 0;
        while (exec_next !== 1'b1 && c < 1100) begin
            @(posedge clk);
            #1 c++;
        end
        if (c >= 1100) begin
            err_count++;
            print_verdict();
        end
    endtask

    initial begin
        {rst_n, reg_wr, reg_rd, sleep_op, wdc, kick_ext, addr, wd, kick_per} = '0;
        void'($urandom(32'hbd71));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(4'h6, d);
        chk("pwr_status", 8'h03, d);
        rd(4'h7, d);
        chk("osc_mode", 8'h01, d);
        r = 8'($urandom);
        wr(4'h2, r);
        rd(4'h2, d);
        chk("per_ien2", r, d);
        rd(4'hc, d);
        chk("unmapped", 8'h00, d);
        pulse(1'b0, 1'b1, 1'b0, 8'h00);
        rd(4'h8, d);
        chk("watchdog", 8'h00, d);
        rd(4'h6, d);
        chk("pwr_status", 8'h03, d);
        // Wake already pending: sleep must fall through
        wr(4'h0, 8'h10);
        pulse(1'b0, 1'b0, 1'b1, 8'h00);
        pulse(1'b1, 1'b0, 1'b0, 8'h00);
        chk("stall", 1'b0, core_stall);
        rd(4'h6, d);
        chk("pwr_status", 8'h03, d);
        rd(4'h9, d);
        chk("evt_status", 8'h02, d);
        // Vectored wake, external clock
        wr(4'ha, 8'h0f);
        wr(4'h0, 8'h90);
        wr(4'h7, 8'h03);
        wr(4'hb, 8'h01);
        pulse(1'b1, 1'b0, 1'b0, 8'h00);
        chk("stall", 1'b1, core_stall);
        chk("osc_run", 1'b0, osc_run);
        chk("irq", 1'b1, irq);
        rd(4'h6, d);
        chk("pwr_status", 8'h06, d);
        rd(4'h8, d);
        chk("watchdog", 8'h00, d);
        wr(4'ha, 8'h01);
        #1 chk("irq", 1'b0, irq);
        pulse(1'b0, 1'b0, 1'b1, 8'h00);
        wait_exec();
        repeat (3) @(posedge clk);
        #1 chk("vector_jump", 1'b1, vector_jump);
        chk("vector_addr", 13'h0004, vaddr);
        // Every clock mode, global enable off, random peripheral source
        for (int m = 0; m < 5; m++) begin
            b = $urandom % 8;
            wr(4'h0, 8'h00);
            wr(4'h3, 8'h00);
            wr(4'h7, 8'(m));
            wr(4'h1, 8'h01 << b);
            pulse(1'b1, 1'b0, 1'b0, 8'h00);
            pulse(1'b0, 1'b0, 1'b0, 8'h01 << b);
            wait_exec();
            chk("wake_delay", 1'b1, (m < 3) ? (c >= 1024 && c < 1050) : (c < 16));
            repeat (3) @(posedge clk);
            #1 chk("vector_jump", 1'b0, vector_jump);
        end
        print_verdict();
    end
endmodule // sleep_wake_controller_tb
`default_nettype wire
